/* kps_keypad.sv */
// Behavioural keypad matrix with row pull-ups
`timescale 1ns/1ps
`default_nettype none
module kps_keypad
	import kps_pkg::*;
(
	// Column drives and key contacts
	input wire logic [KPS_COLS-1:0] col_drive_n,
	input wire logic [29:0] pressed,
	// Rows, pulled up when open
	output logic [KPS_ROWS-1:0] row_sense_n
);
	always_comb begin
		row_sense_n = SENSE_RST;
		for (int c = 0; c < KPS_COLS; c++) begin
			for (int r = 0; r < KPS_ROWS; r++) begin
				if (pressed[c * KPS_ROWS + r] && !col_drive_n[c]) begin
					row_sense_n[r] = 1'b0;
				end
			end
		end
	end
endmodule // kps_keypad
`default_nettype wire

/* kps_pkg.sv */
// Shared constants and types for the keypad scanner
package kps_pkg;
	localparam int KPS_COLS = 5;
	localparam int KPS_ROWS = 6;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_DRIVE = 8'hD1;
	localparam logic [7:0] IDX_SENSE = 8'hD2;
	localparam logic [7:0] IDX_TIMING = 8'hD3;
	localparam logic [7:0] IDX_CTRL = 8'hD4;
	localparam logic [7:0] IDX_SEQ_LO = 8'hD5;
	localparam logic [7:0] IDX_SEQ_HI = 8'hD6;
	localparam logic [7:0] IDX_MCLK = 8'hD7;
	// Reset values
	localparam logic [4:0] DRIVE_RST = 5'h1F;
	localparam logic [5:0] SENSE_RST = 6'h3F;
	localparam logic [7:0] TIMING_RST = 8'h00;
	localparam logic [7:0] SEQ_LO_RST = 8'h88;
	localparam logic [7:0] SEQ_HI_RST = 8'h46;
	localparam logic [7:0] MCLK_RST = 8'h00;
	localparam logic [4:0] ALL_COLS_LOW = 5'h00;
	// Field positions
	localparam int CTRL_IRQ_EN = 0;
	localparam int CTRL_FLAG = 1;
	localparam int CTRL_HW_ON = 2;
	localparam int CTRL_TICK = 3;
	localparam int MCLK_SLOW_OSC = 3;
	localparam int MCLK_BLOCK_ON = 6;
	localparam int SEQ_FIELD_W = 3;
	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_PS;
	localparam logic [8:0] SETTLE_STEP_MS = 9'h004;
	localparam logic [6:0] SETTLE_ZERO_CODE = 7'h40;
	localparam logic [8:0] PROBE_ZERO_MS = 9'h004;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [4:0] {
		KPS_IDLE = 5'b00001,
		KPS_PRESS_DEB = 5'b00010,
		KPS_SCAN = 5'b00100,
		KPS_REL_WAIT = 5'b01000,
		KPS_REL_DEB = 5'b10000
	} kps_state_e;

	typedef struct packed {
		kps_state_e st;
		logic [4:0] drive;
		logic [5:0] sense;
		logic [7:0] timing;
		logic [7:0] seq_lo;
		logic [7:0] seq_hi;
		logic [7:0] mclk;
		logic hw_on;
		logic irq_en;
		logic flag;
		logic [5:0] rows_s1;
		logic [5:0] rows_s2;
		logic ref_s1;
		logic ref_s2;
		logic ref_s3;
		logic [17:0] div;
		logic tick;
		logic [8:0] ms_cnt;
		logic [2:0] pos;
		logic [2:0] row;
		logic [1:0] hits;
		logic [4:0] hit_col;
		logic [5:0] hit_row;
		logic [4:0] col_out;
		logic irq;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic ready;
	} kps_state_s;
endpackage

/* kps_top.sv */
// Keypad matrix scanner with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Five active-low column drives, six row senses; low row on low column is a key.
// - Auto mode idle drives all columns low and waits for any row low.
// - First low row waits one settle time, rechecks, else returns to waiting.
// - Settle time set by firmware from 4 ms to 256 ms in 4 ms steps.
// - Scan drives one column low at a time, checking every row before moving on.
// - Gap between row checks is the 2-bit probe interval, 1 to 4 ms.
// - Columns follow the sequence registers; row order is fixed.
// - Whole keypad scanned; exactly one pressed key is valid, else nothing reported.
// - Valid key loads drive and sensed line registers and raises the key flag.
// - In auto mode those registers change only when a valid key is found.
// - Scanning proceeds without waiting for the flag to be serviced.
// - After any result wait release, settle it, restart if bounced, then idle.
// - Auto off: columns follow the drive line register, last value held.
// - Auto scanning is off after reset and must be enabled by firmware.
// - All timing uses a tick from the 1 kHz slow reference or the main clock divided by TICK_DIV, 200 by default.
// - Drive line bits 4:0 map to column pins, zero meaning driven low.
// - Sensed line bits 5:0 map to row pins, zero meaning low.
// - Keypad block enable gates both scanning and settle logic.
// - Settle code times 4 ms, code zero meaning 256 ms, presses and releases.
// - Hardware search bit set scans automatically, cleared means manual bypass.
module kps_top
	import kps_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Keypad pins
	output logic [KPS_COLS-1:0] col_drive_n,
	input wire logic [KPS_ROWS-1:0] row_sense_n,
	// Slow 1 kHz reference and key flag
	input wire logic slow_tick_ref,
	output logic key_irq
);
	kps_state_s r;
	kps_state_s n;
	logic [14:0] seq;
	logic [2:0] cur_col;
	logic [4:0] scan_pat;
	logic [8:0] settle_ms;
	logic [8:0] probe_ms;
	logic [5:0] dbt;
	logic active;
	logic rows_idle;
	logic expire;
	logic addr_ok;
	logic [7:0] a_idx;
	logic [7:0] rd_byte;
	logic [7:0] wbyte;

	assign seq = {r.seq_hi[6:0], r.seq_lo};
	assign dbt = r.timing[7:2];
	assign active = r.hw_on && r.mclk[MCLK_BLOCK_ON];
	assign rows_idle = &r.rows_s2;
	assign expire = r.tick && (r.ms_cnt <= 9'h001);
	assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
	assign a_idx = haddr[9:2];
	assign wbyte = hwdata[7:0];
	assign cur_col = seq[r.pos*SEQ_FIELD_W +: SEQ_FIELD_W];

	// Code zero means the longest settle time
	always_comb begin
		if (dbt == 6'h00) begin
			settle_ms = 9'({2'b00, SETTLE_ZERO_CODE} * SETTLE_STEP_MS);
		end else begin
			settle_ms = 9'({3'b000, dbt} * SETTLE_STEP_MS);
		end
	end

	always_comb begin
		if (r.timing[1:0] == 2'b00) begin
			probe_ms = PROBE_ZERO_MS;
		end else begin
			probe_ms = {7'h00, r.timing[1:0]};
		end
	end

	// Out-of-range sequence entries drive no column
	always_comb begin
		scan_pat = DRIVE_RST;
		if (cur_col < 3'(KPS_COLS)) begin
			scan_pat[cur_col] = 1'b0;
		end
	end

	always_comb begin
		unique case (a_idx)
			IDX_DRIVE: rd_byte = {3'b000, r.drive};
			IDX_SENSE: rd_byte = {2'b00, r.sense};
			IDX_TIMING: rd_byte = r.timing;
			IDX_CTRL: rd_byte = {4'h0, r.tick, r.hw_on, r.flag, r.irq_en};
			IDX_SEQ_LO: rd_byte = r.seq_lo;
			IDX_SEQ_HI: rd_byte = r.seq_hi;
			IDX_MCLK: rd_byte = r.mclk;
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		n = r;
		n.ready = 1'b1;
		n.rows_s1 = row_sense_n;
		n.rows_s2 = r.rows_s1;
		n.ref_s1 = slow_tick_ref;
		n.ref_s2 = r.ref_s1;
		n.ref_s3 = r.ref_s2;
		n.tick = 1'b0;
		// Main clock divider keeps running so a source switch is glitch free
		if (r.div >= 18'(TICK_DIV - 1)) begin
			n.div = 18'h00000;
		end else begin
			n.div = r.div + 18'h00001;
		end
		if (r.mclk[MCLK_SLOW_OSC]) begin
			n.tick = r.ref_s2 && !r.ref_s3;
		end else begin
			n.tick = r.div == 18'h00000;
		end

		// Bus write data phase
		n.wr_pend = addr_ok && hwrite;
		n.wr_idx = a_idx;
		if (r.wr_pend) begin
			unique case (r.wr_idx)
				IDX_DRIVE: begin
					if (!r.hw_on) begin
						n.drive = wbyte[4:0];
					end
				end
				IDX_TIMING: n.timing = wbyte;
				IDX_CTRL: begin
					n.irq_en = wbyte[CTRL_IRQ_EN];
					n.hw_on = wbyte[CTRL_HW_ON];
					if (wbyte[CTRL_FLAG]) begin
						n.flag = 1'b0;
					end
				end
				IDX_SEQ_LO: n.seq_lo = wbyte;
				IDX_SEQ_HI: n.seq_hi = wbyte;
				IDX_MCLK: n.mclk = wbyte;
				default: ;
			endcase
		end
		if (addr_ok && !hwrite) begin
			n.rdata = {24'h000000, rd_byte};
		end

		// Bypass: sensed line shows live rows
		if (!r.hw_on) begin
			n.sense = r.rows_s2;
		end

		if (r.tick && r.ms_cnt != 9'h000) begin
			n.ms_cnt = r.ms_cnt - 9'h001;
		end

		if (!active) begin
			n.st = KPS_IDLE;
			n.col_out = r.drive;
		end else begin
			unique case (r.st)
				KPS_IDLE: begin
					n.col_out = ALL_COLS_LOW;
					// Scan entry must find the first sequence slot
					n.pos = 3'h0;
					if (!rows_idle) begin
						n.ms_cnt = settle_ms;
						n.st = KPS_PRESS_DEB;
					end
				end
				KPS_PRESS_DEB: begin
					if (expire) begin
						if (!rows_idle) begin
							n.st = KPS_SCAN;
							n.pos = 3'h0;
							n.row = 3'h0;
							n.hits = 2'h0;
							n.ms_cnt = probe_ms;
							n.col_out = scan_pat;
						end else begin
							n.st = KPS_IDLE;
						end
					end
				end
				KPS_SCAN: begin
					n.col_out = scan_pat;
					if (expire) begin
						n.ms_cnt = probe_ms;
						if (!r.rows_s2[r.row]) begin
							if (r.hits != 2'h2) begin
								n.hits = r.hits + 2'h1;
							end
							n.hit_col = scan_pat;
							n.hit_row = ~(6'h01 << r.row);
						end
						if (r.row == 3'(KPS_ROWS - 1)) begin
							n.row = 3'h0;
							if (r.pos == 3'(KPS_COLS - 1)) begin
								// Keeps the sequence slice in range
								n.pos = 3'h0;
								n.st = KPS_REL_WAIT;
								n.col_out = ALL_COLS_LOW;
							end else begin
								n.pos = r.pos + 3'h1;
							end
						end else begin
							n.row = r.row + 3'h1;
						end
					end
				end
				KPS_REL_WAIT: begin
					n.col_out = ALL_COLS_LOW;
					if (rows_idle) begin
						n.ms_cnt = settle_ms;
						n.st = KPS_REL_DEB;
					end
				end
				KPS_REL_DEB: begin
					n.col_out = ALL_COLS_LOW;
					if (!rows_idle) begin
						n.ms_cnt = settle_ms;
					end else if (expire) begin
						n.st = KPS_IDLE;
					end
				end
				default: n.st = KPS_IDLE;
			endcase
		end

		// Result latch; a set wins over a same-cycle clear
		if (active && r.st == KPS_SCAN && expire &&
			r.row == 3'(KPS_ROWS - 1) && r.pos == 3'(KPS_COLS - 1)) begin
			if (n.hits == 2'h1) begin
				n.drive = n.hit_col;
				n.sense = n.hit_row;
				n.flag = 1'b1;
			end
		end
		n.irq = n.flag && n.irq_en;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r.st <= KPS_IDLE;
			r.drive <= DRIVE_RST;
			r.sense <= SENSE_RST;
			r.timing <= TIMING_RST;
			r.seq_lo <= SEQ_LO_RST;
			r.seq_hi <= SEQ_HI_RST;
			r.mclk <= MCLK_RST;
			r.hw_on <= 1'b0;
			r.irq_en <= 1'b0;
			r.flag <= 1'b0;
			r.rows_s1 <= SENSE_RST;
			r.rows_s2 <= SENSE_RST;
			r.ref_s1 <= 1'b0;
			r.ref_s2 <= 1'b0;
			r.ref_s3 <= 1'b0;
			r.div <= 18'h00000;
			r.tick <= 1'b0;
			r.ms_cnt <= 9'h000;
			r.pos <= 3'h0;
			r.row <= 3'h0;
			r.hits <= 2'h0;
			r.hit_col <= DRIVE_RST;
			r.hit_row <= SENSE_RST;
			r.col_out <= DRIVE_RST;
			r.irq <= 1'b0;
			r.wr_pend <= 1'b0;
			r.wr_idx <= 8'h00;
			r.rdata <= 32'h00000000;
			r.ready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign hrdata = r.rdata;
	assign hreadyout = r.ready;
	// Only OKAY responses exist
	assign hresp = 1'b0;
	assign col_drive_n = r.col_out;
	assign key_irq = r.irq;
endmodule // kps_top

`default_nettype wire

/* kps_top_monitor.sv */
// Port assertions for the keypad scanner
`timescale 1ns/1ps
`default_nettype none
module kps_top_monitor
	import kps_pkg::*;
(
	// Clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Keypad side
	input wire logic [KPS_COLS-1:0] col_drive_n,
	input wire logic key_irq
);
	logic ap, aw, au, on;
	logic [7:0] ai;
	logic [4:0] wc;
	logic [2:0] age;
	wire logic dw = ap && aw;
	// Mirror of mode bits, since ports alone cannot show them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap <= 1'b0;
			aw <= 1'b0;
			ai <= 8'h00;
			au <= 1'b0;
			on <= 1'b0;
			wc <= DRIVE_RST;
			age <= 3'h7;
		end else begin
			ap <= hsel && hready && htrans == HTRANS_NONSEQ;
			aw <= hwrite;
			ai <= haddr[9:2];
			age <= dw ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
			if (dw && ai == IDX_CTRL) au <= hwdata[CTRL_HW_ON];
			if (dw && ai == IDX_MCLK) on <= hwdata[MCLK_BLOCK_ON];
			if (dw && ai == IDX_DRIVE) wc <= hwdata[4:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	rst_state_a: assert property ($rose(hresetn) |->
		col_drive_n == DRIVE_RST && !key_irq) else $error("reset state");
	rd_hold_a: assert property ($changed(hrdata) |-> ap && !aw)
		else $error("read data moved");
	rd_top_a: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits");
	scan_cols_a: assert property (au && on && $past(au, 3) && $past(on, 3)
		|-> col_drive_n == 5'h00 || $countones(col_drive_n) >= 4)
		else $error("more than one column scanned");
	man_follow_a: assert property (dw && ai == IDX_DRIVE && !au
		|-> ##[1:2] col_drive_n == wc) else $error("columns ignore write");
	irq_fall_a: assert property ($fell(key_irq) |-> age < 3'h4)
		else $error("key flag dropped alone");
	done_cols_a: assert property ($rose(key_irq) && age == 3'h7 && au
		|-> ##[0:2] col_drive_n == 5'h00) else $error("no release wait");
	bus_ok_a: assert property (hreadyout && !hresp)
		else $error("bus answer");
endmodule // kps_top_monitor
bind kps_top kps_top_monitor i_kps_top_monitor (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout,
	.hresp, .col_drive_n, .key_irq);
`default_nettype wire

/* kps_top_tb_top.sv */
// Register-level tests of the keypad scanner
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module kps_top_tb_top;
	import kps_pkg::*;
	logic hclk, hresetn, hsel, hwrite, rdy, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [4:0] col;
	logic [5:0] row;
	logic [29:0] pk;
	logic sref;
	int failures, samples_checked, n;
	logic [7:0] rv [8] = '{8'h00, 8'h1F, 8'h3F, 8'h00,
		8'h00, 8'h88, 8'h46, 8'h00};
	// Short tick divider: one ms is 20 clocks
	kps_top #(.TICK_DIV(20)) i_kps_top (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hready(rdy), .hwdata, .hrdata,
		.hreadyout(rdy), .hresp, .col_drive_n(col), .row_sense_n(row),
		.slow_tick_ref(sref), .key_irq(irq));
	kps_keypad i_kps_keypad (.col_drive_n(col), .pressed(pk), .row_sense_n(row));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Slow reference: one rising edge every 40 clocks
	initial begin
		sref = 1'b0;
		forever begin
			repeat (20) @(posedge hclk);
			sref <= ~sref;
		end
	end
	task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, i, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (rdy !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] i, e, m);
		bus(i, 1'b0, 8'h00);
		`CHK("register", {i, e & m}, {i, q[7:0] & m})
	endtask
	// Counts clocks while the columns hold one pattern
	task automatic wait_col(input logic [4:0] v);
		n = 0;
		while (col === v && n < 12000) begin
			@(posedge hclk);
			n++;
		end
	endtask
	task automatic wait_irq;
		n = 0;
		while (irq !== 1'b1 && n < 12000) begin
			@(posedge hclk);
			n++;
		end
		`CHK("key_irq", 1'b1, irq)
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge hclk);
		failures++;
		results();
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, pk} = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		`CHK("col", 5'h1F, col)
		for (int k = 0; k < 8; k++) begin
			rd(8'(8'hD0 + k), rv[k], k == 4 ? 8'hF7 : 8'hFF);
		end
		$display("reset test done");
		// Bypass: a second key sits on an undriven column
		for (int c = 0; c < 5; c++) begin
			pk <= (30'h1 << (7 * c)) | (30'h1 << ((c + 1) % 5 * 6 + 5));
			bus(IDX_DRIVE, 1'b1, 8'h1F ^ (8'h1 << c));
			// Rows pass the two-stage synchroniser before they show
			repeat (4) @(posedge hclk);
			rd(IDX_SENSE, 8'h3F ^ (8'h1 << c), 8'hFF);
			`CHK("col", 5'h1F ^ (5'h1 << c), col)
		end
		pk <= '0;
		$display("bypass test done");
		bus(IDX_TIMING, 1'b1, 8'h05);
		bus(IDX_MCLK, 1'b1, 8'h40);
		bus(IDX_CTRL, 1'b1, 8'h05);
		repeat (4) @(posedge hclk);
		`CHK("col", 5'h00, col)
		pk <= 30'h1 << 15;
		wait_col(5'h00);
		`CHK("settle 4ms", 1'b1, n >= 60 && n <= 110)
		wait_irq();
		rd(IDX_DRIVE, 8'h1B, 8'hFF);
		rd(IDX_SENSE, 8'h37, 8'hFF);
		rd(IDX_CTRL, 8'h07, 8'hF7);
		bus(IDX_DRIVE, 1'b1, 8'h00);
		rd(IDX_DRIVE, 8'h1B, 8'hFF);
		pk <= '0;
		bus(IDX_CTRL, 1'b1, 8'h07);
		rd(IDX_CTRL, 8'h05, 8'hF7);
		`CHK("key_irq", 1'b0, irq)
		repeat (200) @(posedge hclk);
		$display("valid key test done");
		// Two keys, then a bounce shorter than the settle time
		pk <= (30'h1 << 0) | (30'h1 << 29);
		repeat (900) @(posedge hclk);
		`CHK("key_irq", 1'b0, irq)
		rd(IDX_DRIVE, 8'h1B, 8'hFF);
		pk <= '0;
		repeat (200) @(posedge hclk);
		// First column, first row: caught at once if no recheck
		pk <= 30'h1;
		repeat (30) @(posedge hclk);
		pk <= '0;
		repeat (300) @(posedge hclk);
		`CHK("key_irq", 1'b0, irq)
		`CHK("col", 5'h00, col)
		$display("reject test done");
		// Slow reference as tick source, 3 ms probe
		bus(IDX_TIMING, 1'b1, 8'h07);
		bus(IDX_MCLK, 1'b1, 8'h48);
		pk <= 30'h1 << 15;
		wait_col(5'h00);
		`CHK("slow settle", 1'b1, n >= 115 && n <= 175)
		`CHK("col", 5'h1E, col)
		wait_col(5'h1E);
		`CHK("probe 3ms", 1'b1, n >= 710 && n <= 730)
		wait_irq();
		pk <= '0;
		bus(IDX_CTRL, 1'b1, 8'h07);
		bus(IDX_MCLK, 1'b1, 8'h40);
		repeat (300) @(posedge hclk);
		$display("slow tick test done");
		// Reverse column order, longest settle, slowest probe
		bus(IDX_SEQ_LO, 1'b1, 8'h9C);
		bus(IDX_SEQ_HI, 1'b1, 8'h02);
		bus(IDX_TIMING, 1'b1, 8'h00);
		pk <= 30'h1 << 6;
		wait_col(5'h00);
		`CHK("settle 256ms", 1'b1, n >= 5100 && n <= 5150)
		`CHK("col", 5'h0F, col)
		wait_col(5'h0F);
		`CHK("probe 4ms", 1'b1, n >= 450 && n <= 490)
		`CHK("col", 5'h17, col)
		wait_irq();
		rd(IDX_DRIVE, 8'h1D, 8'hFF);
		rd(IDX_SENSE, 8'h3E, 8'hFF);
		pk <= '0;
		bus(IDX_MCLK, 1'b1, 8'h00);
		repeat (3) @(posedge hclk);
		`CHK("col", 5'h1D, col)
		$display("order test done");
		results();
	end
endmodule // kps_top_tb_top
`default_nettype wire
